// ==== bench/cpa_mem_model.sv ====
/*
 * Internal space model: 1024 words of 36 bits behind the access block.
 * Assumes the block reads it combinationally at its current address.
 */
`timescale 1ns/1ns
module cpa_mem_model (
    // Access from the block.
    input  wire        clk_i,
    input  wire [9:0]  int_addr_i,
    input  wire        int_wr_i,
    input  wire [35:0] int_wdata_i,
    output wire [35:0] int_rdata_o
);
    reg     [35:0] mem [0:1023];
    integer        i;
    // Each word starts as its own address, so a read shows where it landed.
    initial begin
        for (i = 0; i < 1024; i = i + 1) begin
            mem[i] = i;
        end
    end
    always @(posedge clk_i) begin
        if (int_wr_i) begin
            mem[int_addr_i] <= int_wdata_i;
        end
    end
    assign int_rdata_o = mem[int_addr_i];
endmodule

// ==== bench/cpa_top_asserts.sv ====
/*
 * Handshake checker for the control port access top.
 * Assumes it is bound to cpa_top and sees only its ports.
 */
`timescale 1ns/1ns
module cpa_top_asserts (
    input wire clk_i,
    input wire rstn_i,
    input wire mode_i,
    input wire cs_n_i,
    input wire rd_n_i,
    input wire wr_n_i,
    input wire ready_o,
    input wire transfer_ack_n_o,
    input wire data_oe_o,
    input wire ser_word_end_i,
    input wire ser_rvalid_o,
    input wire int_wr_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    // Access start with no serial word in flight, so no arbitration delay.
    sequence s_take;
        $fell(cs_n_i) && !(rd_n_i && wr_n_i) && !ser_word_end_i && !$past(ser_word_end_i);
    endsequence
    sequence s_rdy_pulse;
        !ready_o ##[1:3] ready_o;
    endsequence
    sequence s_ack_pulse;
        transfer_ack_n_o ##[1:3] !transfer_ack_n_o;
    endsequence
    property p_rst_vals;
        @(posedge clk_i) disable iff (1'b0) !rstn_i |-> ready_o && transfer_ack_n_o && !data_oe_o;
    endproperty
    property p_m0_ack;
        !mode_i && !$past(mode_i) |-> transfer_ack_n_o;
    endproperty
    property p_m1_rdy;
        mode_i && $past(mode_i) |-> ready_o;
    endproperty
    property p_rdy_take;
        (!mode_i) and s_take |=> s_rdy_pulse;
    endproperty
    property p_ack_take;
        mode_i and s_take |=> s_ack_pulse;
    endproperty
    property p_ack_hold;
        mode_i && !transfer_ack_n_o && !rd_n_i && !cs_n_i |=> !transfer_ack_n_o;
    endproperty
    property p_ack_cs;
        mode_i && cs_n_i && $past(cs_n_i) |-> transfer_ack_n_o;
    endproperty
    property p_rvalid;
        ser_rvalid_o |-> $past(ser_word_end_i, 3);
    endproperty
    property p_wr_pulse;
        int_wr_o |=> !int_wr_o;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("outputs not idle in reset");
    a_m0_ack: assert property (p_m0_ack) else $error("ack low in strobe mode");
    a_m1_rdy: assert property (p_m1_rdy) else $error("ready low in select mode");
    a_rdy_take: assert property (p_rdy_take) else $error("ready pulse wrong");
    a_ack_take: assert property (p_ack_take) else $error("ack timing wrong");
    a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
    a_ack_cs: assert property (p_ack_cs) else $error("ack not forced high");
    a_rvalid: assert property (p_rvalid) else $error("serial read not word aligned");
    a_wr_pulse: assert property (p_wr_pulse) else $error("internal write too long");
endmodule
bind cpa_top cpa_top_asserts chk_u (.clk_i(clk_i), .rstn_i(rstn_i), .mode_i(mode_i), .cs_n_i(cs_n_i),
    .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .ready_o(ready_o), .transfer_ack_n_o(transfer_ack_n_o),
    .data_oe_o(data_oe_o), .ser_word_end_i(ser_word_end_i), .ser_rvalid_o(ser_rvalid_o), .int_wr_o(int_wr_o));

// ==== bench/tb.sv ====
/*
 * Self-checking bench: parallel accesses in both modes, auto increment,
 * reserved code and serial commands.
 * Assumes the internal space model answers reads combinationally.
 */
`timescale 1ns/1ns
module tb;
    reg          clk_i;
    reg          rstn_i;
    reg          mode_i;
    reg          cs_n_i;
    reg          rd_n_i;
    reg          wr_n_i;
    reg  [2:0]   addr_i;
    reg  [7:0]   data_i;
    reg          serial_cmd_in_i;
    reg          ser_bit_en_i;
    reg          ser_word_end_i;
    wire [7:0]   data_o;
    wire         data_oe_o;
    wire         ready_o;
    wire         transfer_ack_n_o;
    wire [7:0]   ser_rdata_o;
    wire         ser_rvalid_o;
    wire [9:0]   int_addr_o;
    wire         int_wr_o;
    wire         int_rd_o;
    wire [35:0]  int_wdata_o;
    wire [35:0]  int_rdata_i;
    reg  [7:0]   q;
    reg  [7:0]   v [0:3];
    integer      error_cnt;
    integer      num_checks;
    integer      m;
    integer      k;
    integer      rd_cnt;
    cpa_top dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .mode_i(mode_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i),
        .wr_n_i(wr_n_i), .addr_i(addr_i), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
        .ready_o(ready_o), .transfer_ack_n_o(transfer_ack_n_o), .serial_cmd_in_i(serial_cmd_in_i),
        .ser_bit_en_i(ser_bit_en_i), .ser_word_end_i(ser_word_end_i), .ser_rdata_o(ser_rdata_o),
        .ser_rvalid_o(ser_rvalid_o), .int_addr_o(int_addr_o), .int_wr_o(int_wr_o), .int_rd_o(int_rd_o),
        .int_wdata_o(int_wdata_o), .int_rdata_i(int_rdata_i));
    cpa_mem_model mem_u (.clk_i(clk_i), .int_addr_i(int_addr_o), .int_wr_i(int_wr_o),
        .int_wdata_i(int_wdata_o), .int_rdata_o(int_rdata_i));
    // Internal read pulses, one per data register 0 read.
    always @(posedge clk_i) begin
        if (int_rd_o === 1'b1) rd_cnt <= rd_cnt + 1;
    end
    // Clock at 250 MHz.
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // Inputs change one step after the edge.
    task tick;
        begin
            @(posedge clk_i);
            #1;
        end
    endtask
    task chk(input [35:0] seen, input [35:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // One parallel access; the request holds until the handshake is sampled.
    task acc(input wr, input [2:0] a, input [7:0] d);
        integer n;
        begin
            n = 0;
            tick;
            addr_i = a;
            data_i = d;
            cs_n_i = 1'b0;
            rd_n_i = mode_i ? 1'b0 : wr;
            wr_n_i = !wr;
            while (!mode_i && ready_o !== 1'b0 && n < 9) begin
                tick;
                n = n + 1;
            end
            while ((mode_i ? transfer_ack_n_o : !ready_o) !== 1'b0 && n < 9) begin
                tick;
                n = n + 1;
            end
            tick;
            q = data_o;
            if (!wr) chk(data_oe_o, 1'b1);
            chk(n < 9, 1'b1);
            // Chip select sampled high ends the access
            cs_n_i = 1'b1;
            rd_n_i = 1'b1;
            wr_n_i = 1'b1;
        end
    endtask
    // One serial command word, first bit first; q takes any read byte.
    task ser(input [15:0] w);
        integer i;
        begin
            for (i = 15; i >= 0; i = i - 1) begin
                tick;
                serial_cmd_in_i = w[i];
                ser_bit_en_i = 1'b1;
            end
            tick;
            ser_bit_en_i = 1'b0;
            serial_cmd_in_i = 1'b0;
            ser_word_end_i = 1'b1;
            tick;
            ser_word_end_i = 1'b0;
            q = 8'h00;
            for (i = 0; i < 4; i = i + 1) begin
                if (ser_rvalid_o === 1'b1) q = ser_rdata_o;
                tick;
            end
        end
    endtask
    function [7:0] eb(input [9:0] a, input [9:0] b, input w);
        eb = (a == b + w) ? 8'hB0 : (a == b) ? 8'hA0 : a[7:0];
    endfunction
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    // Watchdog: the tests need a few hundred cycles at most.
    initial begin
        #60000;
        error_cnt = error_cnt + 1;
        finish_test;
    end
    initial begin
        {rstn_i, mode_i, rd_n_i, wr_n_i, cs_n_i} = 5'h17;
        {addr_i, data_i, serial_cmd_in_i, ser_bit_en_i, ser_word_end_i} = 14'h0000;
        error_cnt = 0;
        num_checks = 0;
        rd_cnt = 0;
        {v[3], v[2], v[1], v[0]} = 32'hCBEF5A3C;
        // Reset falls after time zero, so the design sees a real falling edge.
        #1;
        rstn_i = 1'b0;
        repeat (4) tick;
        chk({ready_o, transfer_ack_n_o, data_oe_o}, 3'h6);
        rstn_i = 1'b1;
        // Wide transfer and read back in both handshake modes.
        for (m = 0; m < 2; m = m + 1) begin
            mode_i = m;
            acc(1, 3'h7, 8'h03);
            acc(1, 3'h6, 8'h03);
            for (k = 3; k >= 0; k = k - 1) acc(1, k, v[k] ^ m[7:0]);
            chk(mem_u.mem[10'h303], {4'h0, v[3] ^ m[7:0], v[2] ^ m[7:0], v[1] ^ m[7:0], v[0] ^ m[7:0]});
            for (k = 0; k < 4; k = k + 1) begin
                acc(0, k, 8'h00);
                chk(q, v[k] ^ m[7:0]);
            end
            acc(0, 3'h4, 8'h00);
            chk(q & 8'h0F, 8'h00);
            $display("mode %0d transfer test done", m);
        end
        mode_i = 1'b0;
        // Every auto increment setting on a fresh base address.
        for (m = 0; m < 4; m = m + 1) begin
            acc(1, 3'h7, {m[1:0], 6'h01});
            acc(1, 3'h6, 8'h10 + 8 * m);
            acc(1, 3'h0, 8'hA0);
            acc(1, 3'h0, 8'hB0);
            acc(0, 3'h0, 8'h00);
            chk(q, eb(10'h110 + 8 * m + 2 * m[1], 10'h110 + 8 * m, m[1]));
            acc(0, 3'h0, 8'h00);
            chk(q, eb(10'h110 + 8 * m + 2 * m[1] + m[0], 10'h110 + 8 * m, m[1]));
        end
        $display("increment test done");
        acc(1, 3'h5, 8'hAA);
        acc(0, 3'h5, 8'h00);
        chk(q, 8'h00);
        // Serial writes, two reads, and words with both or no flags.
        ser(16'h4703);
        ser(16'h4605);
        ser(16'h80FF);
        chk(q, 8'h05);
        ser(16'hC6AA);
        ser(16'h06AA);
        ser(16'h86EE);
        chk(q, 8'h05);
        acc(0, 3'h6, 8'h00);
        chk(q, 8'h05);
        ser(16'h4077);
        chk(mem_u.mem[10'h305][7:0], 8'h77);
        chk(rd_cnt, 11);
        $display("serial test done");
        finish_test;
    end
endmodule

// ==== include/cpa_defs.vh ====
/*
 * Constants of the control port access block: external register codes,
 * address mode fields, serial command layout and handshake edge counts.
 * Assumes inclusion by bare name from files under rtl/.
 */
`ifndef CPA_DEFS_VH
`define CPA_DEFS_VH

// External 3-bit register codes.
`define CPA_EXT_DR0       3'h0
`define CPA_EXT_DR1       3'h1
`define CPA_EXT_DR2       3'h2
`define CPA_EXT_DR3       3'h3
`define CPA_EXT_DR4       3'h4
`define CPA_EXT_RSVD      3'h5
`define CPA_EXT_LAR       3'h6
`define CPA_EXT_AMR       3'h7

// Address mode register fields.
`define CPA_AMR_HI_LSB    0
`define CPA_AMR_HI_MSB    1
`define CPA_AMR_RINC_BIT  6
`define CPA_AMR_WINC_BIT  7
`define CPA_AMR_RESET     8'h00
`define CPA_LAR_RESET     8'h00

// Serial command word fields (16 significant bits).
`define CPA_CMD_RD_BIT    15
`define CPA_CMD_WR_BIT    14
`define CPA_CMD_A_MSB     10
`define CPA_CMD_A_LSB     8
`define CPA_CMD_D_MSB     7
`define CPA_CMD_D_LSB     0
`define CPA_CMD_BITS      5'h10

// Handshake edge counts after the start edge N.
`define CPA_RDY_INT_EDGES 2'h3
`define CPA_RDY_EXT_EDGES 2'h2
`define CPA_ACK_EDGES     2'h3

// Widths.
`define CPA_IADDR_W       10
`define CPA_IDATA_W       36

`endif

// ==== rtl/cpa_ifreg.v ====
/*
 * Interface register file: five data registers, low address and address
 * mode registers, with the internal transfer and auto increment logic.
 * Assumes a single access strobe per cycle from the arbiter above.
 */
`timescale 1ns/1ns
`include "cpa_defs.vh"

module cpa_ifreg (
    // Clock and reset.
    input  wire        clk_i,
    input  wire        rstn_i,
    // Access from the arbiter.
    input  wire        acc_i,
    input  wire        acc_wr_i,
    input  wire [2:0]  acc_addr_i,
    input  wire [7:0]  acc_wdata_i,
    output reg  [7:0]  acc_rdata_o,
    // Internal space.
    output reg  [9:0]  int_addr_o,
    output reg         int_wr_o,
    output reg         int_rd_o,
    output reg  [35:0] int_wdata_o,
    input  wire [35:0] int_rdata_i
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    reg [7:0] data_r [0:4];
    reg [7:0] low_addr_reg_r;
    reg [7:0] addr_mode_reg_r;
    integer   i;

    wire [9:0] iaddr = {addr_mode_reg_r[`CPA_AMR_HI_MSB:`CPA_AMR_HI_LSB], low_addr_reg_r};
    wire       dr0_acc = acc_i && (acc_addr_i == `CPA_EXT_DR0);
    wire       do_inc = dr0_acc && (acc_wr_i ? addr_mode_reg_r[`CPA_AMR_WINC_BIT]
                                             : addr_mode_reg_r[`CPA_AMR_RINC_BIT]);
    wire [9:0] iaddr_inc = iaddr + 10'h001;

    // Address register values after this edge. The internal address port follows them, so a
    // combinational internal read always sees the location the registers point at.
    // Limitation: for one cycle after a data register 0 write the port still shows the
    // written location, so a read in that very cycle would see the old address.
    wire       lar_wr  = acc_i && acc_wr_i && (acc_addr_i == `CPA_EXT_LAR);
    wire       amr_wr  = acc_i && acc_wr_i && (acc_addr_i == `CPA_EXT_AMR);
    wire [7:0] lar_nxt = do_inc ? iaddr_inc[7:0] : (lar_wr ? acc_wdata_i : low_addr_reg_r);
    wire [1:0] ahi_nxt = do_inc ? iaddr_inc[9:8]
                       : (amr_wr ? acc_wdata_i[`CPA_AMR_HI_MSB:`CPA_AMR_HI_LSB]
                                 : addr_mode_reg_r[`CPA_AMR_HI_MSB:`CPA_AMR_HI_LSB]);

    // Register writes, internal transfers and address stepping.
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (i = 0; i < 5; i = i + 1) begin
                data_r[i] <= 8'h00;
            end
            low_addr_reg_r  <= `CPA_LAR_RESET;
            addr_mode_reg_r <= `CPA_AMR_RESET;
            int_wr_o        <= 1'b0;
            int_rd_o        <= 1'b0;
            int_wdata_o     <= 36'h000000000;
            int_addr_o      <= 10'h000;
            acc_rdata_o     <= 8'h00;
        end else begin
            int_wr_o <= 1'b0;
            int_rd_o <= 1'b0;
            int_addr_o <= {ahi_nxt, lar_nxt};
            if (acc_i && acc_wr_i) begin
                case (acc_addr_i)
                    `CPA_EXT_LAR: low_addr_reg_r <= acc_wdata_i;
                    `CPA_EXT_AMR: addr_mode_reg_r <= acc_wdata_i;
                    `CPA_EXT_RSVD: ;
                    `CPA_EXT_DR4: data_r[4] <= {4'h0, acc_wdata_i[3:0]};
                    default: data_r[acc_addr_i] <= acc_wdata_i;
                endcase
            end
            if (dr0_acc && acc_wr_i) begin
                int_wr_o    <= 1'b1;
                int_addr_o  <= iaddr;
                int_wdata_o <= {data_r[4][3:0], data_r[3], data_r[2], data_r[1], acc_wdata_i};
            end
            if (dr0_acc && !acc_wr_i) begin
                int_rd_o  <= 1'b1;
                data_r[0] <= int_rdata_i[7:0];
                data_r[1] <= int_rdata_i[15:8];
                data_r[2] <= int_rdata_i[23:16];
                data_r[3] <= int_rdata_i[31:24];
                data_r[4] <= {4'h0, int_rdata_i[35:32]};
            end
            if (do_inc) begin
                low_addr_reg_r <= iaddr_inc[7:0];
                addr_mode_reg_r[`CPA_AMR_HI_MSB:`CPA_AMR_HI_LSB] <= iaddr_inc[9:8];
            end
            // Read data; DR0 returns the fresh low byte in the same access.
            if (acc_i && !acc_wr_i) begin
                case (acc_addr_i)
                    `CPA_EXT_DR0: acc_rdata_o <= int_rdata_i[7:0];
                    `CPA_EXT_LAR: acc_rdata_o <= low_addr_reg_r;
                    `CPA_EXT_AMR: acc_rdata_o <= addr_mode_reg_r;
                    `CPA_EXT_RSVD: acc_rdata_o <= 8'h00;
                    default: acc_rdata_o <= data_r[acc_addr_i];
                endcase
            end
        end
    end

endmodule

// ==== rtl/cpa_sercmd.v ====
/*
 * Serial command receiver: shifts in command words, decodes the first
 * sixteen bits and raises one access request per word with exactly one flag set.
 * Assumes a bit enable and word boundary strobe from the serial framer.
 */
`timescale 1ns/1ns
`include "cpa_defs.vh"

module cpa_sercmd (
    // Clock and reset.
    input  wire       clk_i,
    input  wire       rstn_i,
    // Serial side.
    input  wire       serial_cmd_in_i,
    input  wire       bit_en_i,
    input  wire       word_end_i,
    // Decoded request.
    output reg        req_o,
    output reg        req_wr_o,
    output reg  [2:0] req_addr_o,
    output reg  [7:0] req_data_o,
    input  wire       req_done_i
);

    reg [15:0] shift_r;
    reg [4:0]  cnt_r;

    // Keep only the first sixteen bits
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shift_r    <= 16'h0000;
            cnt_r      <= 5'h00;
            req_o      <= 1'b0;
            req_wr_o   <= 1'b0;
            req_addr_o <= 3'h0;
            req_data_o <= 8'h00;
        end else begin
            if (req_done_i) begin
                req_o <= 1'b0;
            end
            if (word_end_i) begin
                cnt_r <= 5'h00;
                if (shift_r[`CPA_CMD_RD_BIT] ^ shift_r[`CPA_CMD_WR_BIT]) begin
                    req_o      <= 1'b1;
                    req_wr_o   <= shift_r[`CPA_CMD_WR_BIT];
                    req_addr_o <= shift_r[`CPA_CMD_A_MSB:`CPA_CMD_A_LSB];
                    req_data_o <= shift_r[`CPA_CMD_D_MSB:`CPA_CMD_D_LSB];
                end
            end else if (bit_en_i && cnt_r < `CPA_CMD_BITS) begin
                shift_r <= {shift_r[14:0], serial_cmd_in_i};
                cnt_r   <= cnt_r + 5'h01;
            end
        end
    end

endmodule

// ==== rtl/cpa_top.v ====
/*
 * Control port access top: parallel host port in two handshake modes,
 * serial command path, arbitration and the interface register file.
 * Assumes host pins are synchronous to clk_i and the internal space
 * answers reads combinationally.
 */
`timescale 1ns/1ns
`include "cpa_defs.vh"

module cpa_top (
    // Clock and reset.
    input  wire        clk_i,
    input  wire        rstn_i,
    // Parallel host port.
    input  wire        mode_i,
    input  wire        cs_n_i,
    input  wire        rd_n_i,
    input  wire        wr_n_i,
    input  wire [2:0]  addr_i,
    input  wire [7:0]  data_i,
    output reg  [7:0]  data_o,
    output reg         data_oe_o,
    output reg         ready_o,
    output reg         transfer_ack_n_o,
    // Serial command path.
    input  wire        serial_cmd_in_i,
    input  wire        ser_bit_en_i,
    input  wire        ser_word_end_i,
    output reg  [7:0]  ser_rdata_o,
    output reg         ser_rvalid_o,
    // Internal space.
    output wire [9:0]  int_addr_o,
    output wire        int_wr_o,
    output wire        int_rd_o,
    output wire [35:0] int_wdata_o,
    input  wire [35:0] int_rdata_i
);

    // ------------------------------------------------------------
    // Parallel port states
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_HOLD = 2'h2;
    localparam ST_DONE = 2'h3;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [1:0] cnt_r;
    reg [1:0] cnt_nxt;
    reg       acc_wr_r;
    reg [2:0] acc_addr_r;
    reg       ser_busy_r;
    reg       took_r;

    // Mode 1 data strobe with read/write select
    wire strobe   = mode_i ? !rd_n_i : (!rd_n_i || !wr_n_i);
    wire is_write = mode_i ? !wr_n_i : !wr_n_i;
    wire start    = !cs_n_i && strobe;

    // Serial command decoder.
    wire       s_req;
    wire       s_wr;
    wire [2:0] s_addr;
    wire [7:0] s_data;
    wire       s_take;

    cpa_sercmd u_ser (
        .clk_i           (clk_i),
        .rstn_i          (rstn_i),
        .serial_cmd_in_i (serial_cmd_in_i),
        .bit_en_i        (ser_bit_en_i),
        .word_end_i      (ser_word_end_i),
        .req_o           (s_req),
        .req_wr_o        (s_wr),
        .req_addr_o      (s_addr),
        .req_data_o      (s_data),
        .req_done_i      (s_take)
    );

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    // The parallel access reaches the registers one edge before the handshake answers:
    // ready rises, or acknowledge falls, on the edge after the register access, so the
    // read byte already stands on data_o when the host samples the answer.
    // A serial request pending at the access edge pushes the parallel access back,
    // and the cycle after a serial access is kept free so its read byte is not lost.
    // Serial request wins the shared registers
    assign s_take = s_req;
    wire p_take   = (state_r == ST_WAIT) && !s_req && !ser_busy_r && (cnt_r == 2'h0);

    wire       acc      = s_take || p_take;
    wire       acc_wr   = s_take ? s_wr : acc_wr_r;
    wire [2:0] acc_addr = s_take ? s_addr : acc_addr_r;
    wire [7:0] acc_wd   = s_take ? s_data : data_i;
    wire [7:0] acc_rd;

    cpa_ifreg u_reg (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .acc_i       (acc),
        .acc_wr_i    (acc_wr),
        .acc_addr_i  (acc_addr),
        .acc_wdata_i (acc_wd),
        .acc_rdata_o (acc_rd),
        .int_addr_o  (int_addr_o),
        .int_wr_o    (int_wr_o),
        .int_rd_o    (int_rd_o),
        .int_wdata_o (int_wdata_o),
        .int_rdata_i (int_rdata_i)
    );

    // Count of edges still owed before the handshake completes.
    function [1:0] edges_for;
        input wr;
        input [2:0] a;
        begin
            // Longer read for data register 0
            if (!wr && a == `CPA_EXT_DR0) begin
                edges_for = `CPA_RDY_INT_EDGES;
            end else begin
                edges_for = `CPA_RDY_EXT_EDGES;
            end
        end
    endfunction

    // Next state of the parallel handshake.
    always @* begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_nxt = ST_WAIT;
                    cnt_nxt   = mode_i ? `CPA_ACK_EDGES - 2'h2 : edges_for(is_write, addr_i) - 2'h2;
                end
            end
            ST_WAIT: begin
                if (cnt_r != 2'h0) begin
                    cnt_nxt = cnt_r - 2'h1;
                end else if (p_take) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Completion on sampled chip select high
                if (cs_n_i) begin
                    state_nxt = ST_IDLE;
                end else if (!strobe) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                if (cs_n_i) begin
                    state_nxt = ST_IDLE;
                end else if (strobe) begin
                    state_nxt = ST_WAIT;
                    cnt_nxt   = 2'h0;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Handshake registers and data capture.
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r          <= ST_IDLE;
            cnt_r            <= 2'h0;
            acc_wr_r         <= 1'b0;
            acc_addr_r       <= 3'h0;
            ser_busy_r       <= 1'b0;
            took_r           <= 1'b0;
            ready_o          <= 1'b1;
            transfer_ack_n_o <= 1'b1;
            data_o           <= 8'h00;
            data_oe_o        <= 1'b0;
            ser_rdata_o      <= 8'h00;
            ser_rvalid_o     <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            ser_busy_r <= s_take;
            took_r     <= p_take;
            if ((state_r == ST_IDLE || state_r == ST_DONE) && start) begin
                acc_wr_r   <= is_write;
                acc_addr_r <= addr_i;
            end
            // Mode 0: ready low while busy, or while a serial request is pending outside idle
            // The first hold cycle still counts as busy, so ready rises one edge after the access.
            ready_o <= mode_i || (state_nxt == ST_IDLE) || (state_nxt == ST_DONE)
                       || (state_nxt == ST_HOLD && state_r == ST_HOLD)
                       ? !(s_req && !mode_i && state_nxt != ST_IDLE) : 1'b0;
            // Held until strobe release, forced high by chip select
            transfer_ack_n_o <= !(mode_i && state_r == ST_HOLD && state_nxt == ST_HOLD);
            data_oe_o        <= !cs_n_i && !acc_wr_r && (state_nxt == ST_HOLD);
            if (p_take && !acc_wr_r) begin
                data_o <= (acc_addr_r == `CPA_EXT_DR0) ? int_rdata_i[7:0] : 8'h00;
            end
            // Other registers answer one edge after the access. Loading only then keeps a
            // later serial read from overwriting the byte the host is still holding.
            if (took_r && !acc_wr_r && acc_addr_r != `CPA_EXT_DR0) begin
                data_o <= acc_rd;
            end
            ser_rvalid_o <= ser_busy_r && !s_wr;
            if (ser_busy_r) begin
                ser_rdata_o <= acc_rd;
            end
        end
    end

endmodule
